// >>> hdl/lss_controller.sv
// controller end: link clock, launch pulse and pixel capture
// Notes on behaviour
// - launch stays high at least six periods
// - launch stays low at least 100 periods
// - link clock runs continuously, duty near half
// - sensor steps on first rise after fall
// - integration equals launch high plus 48
// - high and low split sets integration time
// - count strobes from fall; pixel one at 89
// - sensor drives a sampling strobe for pixels
// - keep scan cycle and high period short
// - capture video on each strobe rising edge
// - each scan delivers 4096 pixels in order
`timescale 1ns/1ps
module lss_controller #(
    parameter int unsigned HIGH_PERIODS = lss_pkg::LAUNCH_HIGH_DEF,
    parameter int unsigned LOW_PERIODS  = lss_pkg::LAUNCH_LOW_MIN,
    parameter int unsigned HALF_CYCLES  = lss_pkg::LINK_HALF_CYCLES,
    parameter int unsigned PIXELS       = lss_pkg::PIXEL_COUNT
) (
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    lss_link_if.controller                     link,
    input  wire logic                          run,
    output logic [lss_pkg::PIXEL_W-1:0]        pixelValue,
    output logic [lss_pkg::PIXEL_W-1:0]        pixelNumber,
    output logic                               pixelStrobe,
    output logic                               lineDone,
    output logic                               busy
);
    typedef enum logic [2:0] {
        CT_IDLE = 3'b001,
        CT_HIGH = 3'b010,
        CT_LOW  = 3'b100
    } lss_ctState_t;

    // too short a setting is stretched rather than trusted
    localparam logic [lss_pkg::PHASE_W-1:0] HIGH_LEN =
        lss_pkg::lss_atLeast(HIGH_PERIODS, lss_pkg::LAUNCH_HIGH_MIN);
    localparam logic [lss_pkg::PHASE_W-1:0] LOW_LEN =
        lss_pkg::lss_atLeast(LOW_PERIODS, lss_pkg::LAUNCH_LOW_MIN);
    localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);
    localparam logic [lss_pkg::PULSE_W-1:0] PULSE_LAST =
        lss_pkg::PULSE_W'(lss_pkg::FIRST_PIXEL_PULSE + PIXELS - 1);

    lss_ctState_t                   state, next_state;
    logic [7:0]                     halfCnt, next_halfCnt;
    logic                           linkClk, next_linkClk;
    logic                           launch, next_launch;
    logic [lss_pkg::PHASE_W-1:0]    phaseCnt, next_phaseCnt;
    logic                           fallTick;

    always_comb begin
        next_halfCnt  = halfCnt + 8'h01;
        next_linkClk  = linkClk;
        fallTick      = 1'b0;
        // equal halves keep the duty at one half
        if (halfCnt == HALF_LAST) begin
            next_halfCnt = 8'h00;
            next_linkClk = ~linkClk;
            fallTick     = linkClk;
        end
    end

    // launch moves on link falls so it is settled before the sensor's rise
    always_comb begin
        next_state    = state;
        next_launch   = launch;
        next_phaseCnt = phaseCnt;
        if (fallTick) begin
            next_phaseCnt = phaseCnt + lss_pkg::PHASE_ONE;
            case (state)
                CT_IDLE: begin
                    if (run) begin
                        next_state    = CT_HIGH;
                        next_launch   = 1'b1;
                        next_phaseCnt = lss_pkg::PHASE_ONE;
                    end
                end
                CT_HIGH: begin
                    if (phaseCnt == HIGH_LEN) begin
                        next_state    = CT_LOW;
                        next_launch   = 1'b0;
                        next_phaseCnt = lss_pkg::PHASE_ONE;
                    end
                end
                CT_LOW: begin
                    if (phaseCnt == LOW_LEN) begin
                        next_state    = run ? CT_HIGH : CT_IDLE;
                        next_launch   = run;
                        next_phaseCnt = lss_pkg::PHASE_ONE;
                    end
                end
                default: begin
                    next_state  = CT_IDLE;
                    next_launch = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            halfCnt  <= 8'h00;
            linkClk  <= 1'b0;
            state    <= CT_IDLE;
            launch   <= 1'b0;
            phaseCnt <= '0;
        end else begin
            halfCnt  <= next_halfCnt;
            linkClk  <= next_linkClk;
            state    <= next_state;
            launch   <= next_launch;
            phaseCnt <= next_phaseCnt;
        end
    end

    // capture side: strobes and video come from logic on this same clock
    logic                           capturing, next_capturing;
    logic [lss_pkg::PULSE_W-1:0]    trigNo, next_trigNo;
    logic                           trigPrev, doneQ;
    logic [lss_pkg::PIXEL_W-1:0]    next_pixelValue, next_pixelNumber;
    logic                           next_pixelStrobe, next_lineDone, next_busy;
    logic                           launchFalls;

    always_comb begin
        launchFalls      = launch & ~next_launch;
        next_capturing   = capturing;
        next_trigNo      = trigNo;
        next_pixelValue  = pixelValue;
        next_pixelNumber = pixelNumber;
        next_pixelStrobe = 1'b0;
        next_lineDone    = 1'b0;
        if (capturing && link.sampleStrobe && !trigPrev) begin
            next_trigNo = trigNo + lss_pkg::PULSE_ONE;
            if (next_trigNo >= lss_pkg::PULSE_FIRST) begin
                next_pixelValue  = link.videoPixel;
                next_pixelNumber = lss_pkg::lss_pixelOf(next_trigNo);
                next_pixelStrobe = 1'b1;
            end
            if (next_trigNo == PULSE_LAST) begin
                next_capturing = 1'b0;
                next_lineDone  = 1'b1;
            end
        end
        if (capturing && link.scanDoneFlag && !doneQ && !next_lineDone) begin
            next_capturing = 1'b0;
            next_lineDone  = 1'b1;
        end
        // a fresh launch fall starts a new count, as the sensor restarts too
        if (launchFalls) begin
            next_capturing = 1'b1;
            next_trigNo    = '0;
        end
        next_busy = (next_state != CT_IDLE) | next_capturing;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            capturing   <= 1'b0;
            trigNo      <= '0;
            trigPrev    <= 1'b0;
            doneQ       <= 1'b0;
            pixelValue  <= '0;
            pixelNumber <= '0;
            pixelStrobe <= 1'b0;
            lineDone    <= 1'b0;
            busy        <= 1'b0;
        end else begin
            capturing   <= next_capturing;
            trigNo      <= next_trigNo;
            trigPrev    <= link.sampleStrobe;
            doneQ       <= link.scanDoneFlag;
            pixelValue  <= next_pixelValue;
            pixelNumber <= next_pixelNumber;
            pixelStrobe <= next_pixelStrobe;
            lineDone    <= next_lineDone;
            busy        <= next_busy;
        end
    end

    assign link.linkClk         = linkClk;
    assign link.lineLaunchPulse = launch;
endmodule

// >>> hdl/lss_sensor.sv
// sensor end: integration, readout stepping and sampling strobe
`timescale 1ns/1ps
module lss_sensor #(
    parameter int unsigned PIXELS = lss_pkg::PIXEL_COUNT
) (
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    lss_link_if.sensor                         link,
    output logic                               integrating,
    output logic [lss_pkg::PHASE_W-1:0]        integTime
);
    typedef enum logic [2:0] {
        SN_IDLE  = 3'b001,
        SN_ARMED = 3'b010,
        SN_RUN   = 3'b100
    } lss_rdState_t;

    localparam logic [lss_pkg::PULSE_W-1:0] PULSE_END =
        lss_pkg::PULSE_W'(lss_pkg::FIRST_PIXEL_PULSE + PIXELS);

    // pins from the far end: three flops, level accepted when two and three agree
    logic clkS1, clkS2, clkS3, clkLvl;
    logic lnS1, lnS2, lnS3, lnLvl;
    lss_rdState_t                   state, next_state;
    logic [lss_pkg::PULSE_W-1:0]    pulseNo, next_pulseNo;
    logic [lss_pkg::PHASE_W-1:0]    integCnt, next_integCnt, tailCnt, next_tailCnt;
    logic [lss_pkg::PHASE_W-1:0]    next_integTime;
    logic                           tailOn, next_tailOn, next_integrating;
    logic                           trig, next_trig, done, next_done;
    logic [lss_pkg::PIXEL_W-1:0]    pixel, next_pixel;
    logic                           next_clkLvl, next_lnLvl;
    logic                           linkRise, launchRise, launchFall;

    always_comb begin
        next_clkLvl = (clkS2 == clkS3) ? clkS3 : clkLvl;
        next_lnLvl  = (lnS2 == lnS3) ? lnS3 : lnLvl;
        linkRise    = clkS2 & clkS3 & ~clkLvl;
        launchRise  = lnS2 & lnS3 & ~lnLvl;
        launchFall  = ~lnS2 & ~lnS3 & lnLvl;
    end

    always_comb begin
        next_state       = state;
        next_pulseNo     = pulseNo;
        next_trig        = trig & clkLvl;
        next_done        = done;
        next_pixel       = pixel;
        next_integCnt    = integCnt;
        next_tailCnt     = tailCnt;
        next_tailOn      = tailOn;
        next_integrating = integrating;
        next_integTime   = integTime;
        // a new launch fall restarts readout even mid-line
        if (launchFall) begin
            next_state = SN_ARMED;
        end
        if (linkRise) begin
            next_done = 1'b0;
            case (state)
                SN_ARMED: begin
                    next_state   = SN_RUN;
                    next_pulseNo = lss_pkg::PULSE_ONE;
                    next_trig    = 1'b1;
                end
                SN_RUN: begin
                    next_pulseNo = pulseNo + lss_pkg::PULSE_ONE;
                    if (next_pulseNo == PULSE_END) begin
                        next_state = SN_IDLE;
                        next_done  = 1'b1;
                    end else begin
                        next_trig = 1'b1;
                        if (next_pulseNo >= lss_pkg::PULSE_FIRST) begin
                            next_pixel = lss_pkg::lss_pixelOf(next_pulseNo);
                        end
                    end
                end
                SN_IDLE: begin
                end
                default: begin
                    next_state = SN_IDLE;
                end
            endcase
            if (integrating && integCnt != lss_pkg::PHASE_MAX) begin
                next_integCnt = integCnt + lss_pkg::PHASE_ONE;
            end
            if (tailOn) begin
                next_tailCnt = tailCnt + lss_pkg::PHASE_ONE;
                if (tailCnt == lss_pkg::TAIL_LAST - lss_pkg::PHASE_ONE) begin
                    next_tailOn      = 1'b0;
                    next_integrating = 1'b0;
                    next_integTime   = next_integCnt;
                end
            end
        end
        if (launchRise) begin
            next_integrating = 1'b1;
            next_integCnt    = '0;
            next_tailOn      = 1'b0;
        end
        if (launchFall) begin
            next_tailOn  = 1'b1;
            next_tailCnt = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clkS1       <= 1'b0;
            clkS2       <= 1'b0;
            clkS3       <= 1'b0;
            clkLvl      <= 1'b0;
            lnS1        <= 1'b0;
            lnS2        <= 1'b0;
            lnS3        <= 1'b0;
            lnLvl       <= 1'b0;
            state       <= SN_IDLE;
            pulseNo     <= '0;
            trig        <= 1'b0;
            done        <= 1'b0;
            pixel       <= '0;
            integCnt    <= '0;
            tailCnt     <= '0;
            tailOn      <= 1'b0;
            integrating <= 1'b0;
            integTime   <= '0;
        end else begin
            clkS1       <= link.linkClk;
            clkS2       <= clkS1;
            clkS3       <= clkS2;
            clkLvl      <= next_clkLvl;
            lnS1        <= link.lineLaunchPulse;
            lnS2        <= lnS1;
            lnS3        <= lnS2;
            lnLvl       <= next_lnLvl;
            state       <= next_state;
            pulseNo     <= next_pulseNo;
            trig        <= next_trig;
            done        <= next_done;
            pixel       <= next_pixel;
            integCnt    <= next_integCnt;
            tailCnt     <= next_tailCnt;
            tailOn      <= next_tailOn;
            integrating <= next_integrating;
            integTime   <= next_integTime;
        end
    end

    assign link.sampleStrobe = trig;
    assign link.videoPixel   = pixel;
    assign link.scanDoneFlag = done;
endmodule

// >>> pkg/lss_link_if.sv
// link between the scan controller and the linear sensor
`timescale 1ns/1ps
interface lss_link_if;
    logic                         linkClk;
    logic                         lineLaunchPulse;
    logic                         sampleStrobe;
    logic [lss_pkg::PIXEL_W-1:0]  videoPixel;
    logic                         scanDoneFlag;

    modport sensor (
        input  linkClk,
        input  lineLaunchPulse,
        output sampleStrobe,
        output videoPixel,
        output scanDoneFlag
    );

    modport controller (
        output linkClk,
        output lineLaunchPulse,
        input  sampleStrobe,
        input  videoPixel,
        input  scanDoneFlag
    );
endinterface

// >>> pkg/lss_pkg.sv
// shared constants and helpers for the linear sensor scan timing ends
package lss_pkg;
    localparam int unsigned CLK_PERIOD_PS     = 5000;
    localparam int unsigned LINK_PERIOD_MIN_NS = 100;
    // least link period rounds up so each half spans whole clk periods
    localparam int unsigned LINK_HALF_CYCLES  =
        (LINK_PERIOD_MIN_NS * 1000 + 2 * CLK_PERIOD_PS - 1) / (2 * CLK_PERIOD_PS);
    localparam int unsigned LAUNCH_HIGH_MIN   = 6;
    localparam int unsigned LAUNCH_LOW_MIN    = 100;
    localparam int unsigned LAUNCH_HIGH_DEF   = 4088;
    localparam int unsigned INTEG_TAIL        = 48;
    localparam int unsigned FIRST_PIXEL_PULSE = 89;
    localparam int unsigned PIXEL_COUNT       = 4096;
    localparam int unsigned PIXEL_W           = 12;
    localparam int unsigned PULSE_W           = 13;
    localparam int unsigned PHASE_W           = 16;

    localparam logic [PULSE_W-1:0] PULSE_ONE   = 13'h0001;
    localparam logic [PULSE_W-1:0] PULSE_FIRST = 13'h0059;
    localparam logic [PULSE_W-1:0] PULSE_DONE  = 13'h1059;
    localparam logic [PHASE_W-1:0] PHASE_ONE   = 16'h0001;
    localparam logic [PHASE_W-1:0] PHASE_MAX   = 16'hFFFF;
    localparam logic [PHASE_W-1:0] TAIL_LAST   = 16'h0030;

    // a phase length never shorter than its least value
    function automatic logic [PHASE_W-1:0] lss_atLeast(input int unsigned want,
                                                        input int unsigned least);
        lss_atLeast = (want < least) ? PHASE_W'(least) : PHASE_W'(want);
    endfunction

    // pixel number carried by a given strobe pulse
    function automatic logic [PIXEL_W-1:0] lss_pixelOf(input logic [PULSE_W-1:0] pulseNo);
        lss_pixelOf = PIXEL_W'(pulseNo - PULSE_FIRST);
    endfunction
endpackage

// >>> test/lss_link_assertions.sv
// concurrent checks on the link between the controller and sensor ends
`timescale 1ns/1ps
module lss_link_assertions #(
    parameter int unsigned PIXELS = lss_pkg::PIXEL_COUNT
) (
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire logic                        linkClk,
    input  wire logic                        lineLaunchPulse,
    input  wire logic                        sampleStrobe,
    input  wire logic [lss_pkg::PIXEL_W-1:0] videoPixel,
    input  wire logic                        scanDoneFlag
);
    localparam logic [12:0] LAST = 13'h0058 + 13'(PIXELS);
    logic [15:0] highCnt;
    logic [15:0] next_highCnt;
    logic [15:0] lowCnt;
    logic [15:0] next_lowCnt;
    logic [12:0] pulseCnt;
    logic [12:0] next_pulseCnt;
    logic        armed;
    logic        next_armed;
    logic        prevLaunch;
    logic        prevStrobe;

    // low time only means something once a fall has been seen since reset
    always_comb begin
        next_highCnt = lineLaunchPulse ? highCnt + 16'h0001 : 16'h0000;
        next_lowCnt = lineLaunchPulse ? 16'h0000 : lowCnt + {15'h0000, lowCnt != 16'hFFFF};
        next_armed = armed | (prevLaunch & ~lineLaunchPulse);
        next_pulseCnt = pulseCnt;
        if (prevLaunch && !lineLaunchPulse) begin
            next_pulseCnt = 13'h0000;
        end else if (sampleStrobe && !prevStrobe) begin
            next_pulseCnt = pulseCnt + 13'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            highCnt <= 16'h0000;
            lowCnt <= 16'h0000;
            pulseCnt <= 13'h0000;
            armed <= 1'b0;
            prevLaunch <= 1'b0;
            prevStrobe <= 1'b0;
        end else begin
            highCnt <= next_highCnt;
            lowCnt <= next_lowCnt;
            pulseCnt <= next_pulseCnt;
            armed <= next_armed;
            prevLaunch <= lineLaunchPulse;
            prevStrobe <= sampleStrobe;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence heldTen(s);
        s [*8] ##1 s [*2];
    endsequence

    link_high_a: assert property ($rose(linkClk) |-> heldTen(linkClk) ##1 !linkClk)
        else $error("link clock high half wrong");
    link_low_a: assert property ($fell(linkClk) |-> heldTen(!linkClk) ##1 linkClk)
        else $error("link clock low half wrong");
    launch_high_a: assert property ($fell(lineLaunchPulse) |-> highCnt >= 16'h0078)
        else $error("launch high too short");
    launch_low_a: assert property ($rose(lineLaunchPulse) && armed |->
        lowCnt >= 16'h07D0) else $error("launch low too short");
    first_strobe_a: assert property ($fell(lineLaunchPulse) |->
        !sampleStrobe [*8] ##[1:12] $rose(sampleStrobe)) else $error("first strobe misplaced");
    strobe_phase_a: assert property ($rose(sampleStrobe) |-> linkClk ##[3:8] !linkClk)
        else $error("strobe off the link clock high half");
    strobe_width_a: assert property ($rose(sampleStrobe) |->
        sampleStrobe [*8] ##[1:4] !sampleStrobe) else $error("strobe width wrong");
    pixel_order_a: assert property (
        $rose(sampleStrobe) && pulseCnt >= 13'h0058 |->
        videoPixel == 12'(pulseCnt - 13'h0058)) else $error("video pixel out of order");
    pulse_cap_a: assert property ($rose(sampleStrobe) |-> pulseCnt < LAST)
        else $error("strobe after last pixel");
    done_count_a: assert property ($rose(scanDoneFlag) |->
        pulseCnt == LAST && !sampleStrobe) else $error("scan done at wrong pulse count");
    done_width_a: assert property ($rose(scanDoneFlag) |->
        heldTen(scanDoneFlag) ##1 heldTen(scanDoneFlag) ##1 !scanDoneFlag) else $error("done width");
endmodule

// >>> test/tb_linear_sensor_scan_timing.sv
// self-checking bench joining the controller and sensor ends
`timescale 1ns/1ps
module tb_linear_sensor_scan_timing;
    localparam int unsigned PIX = 16;
    // below the least high time on purpose: the controller must raise it to six
    localparam int unsigned HIGH_SET = 3;
    localparam int unsigned HIGH_EFF = 6;
    localparam int unsigned LOW_SET = 120;
    localparam int unsigned LINK = 20;
    typedef struct packed {
        logic [11:0] num;
        logic        done;
    } lss_row_t;

    logic        clk;
    logic        rst_b;
    logic        run;
    logic [11:0] pixelValue;
    logic [11:0] pixelNumber;
    logic        pixelStrobe;
    logic        lineDone;
    logic        busy;
    logic        integrating;
    logic [15:0] integTime;
    int          fails;
    int          checkCount;
    lss_row_t    rows [PIX];

    lss_link_if lss_link_if_inst ();
    wire logic launch = lss_link_if_inst.lineLaunchPulse;
    wire logic strobe = lss_link_if_inst.sampleStrobe;
    wire logic done = lss_link_if_inst.scanDoneFlag;

    lss_sensor #(.PIXELS(PIX)) lss_sensor_inst (.clk(clk), .rst_b(rst_b),
        .link(lss_link_if_inst.sensor), .integrating(integrating), .integTime(integTime));
    lss_controller #(.HIGH_PERIODS(HIGH_SET), .LOW_PERIODS(LOW_SET), .PIXELS(PIX))
        lss_controller_inst (.clk(clk), .rst_b(rst_b), .link(lss_link_if_inst.controller),
        .run(run), .pixelValue(pixelValue), .pixelNumber(pixelNumber),
        .pixelStrobe(pixelStrobe), .lineDone(lineDone), .busy(busy));
    lss_link_assertions #(.PIXELS(PIX)) lss_link_assertions_inst (.clk(clk), .rst_b(rst_b),
        .linkClk(lss_link_if_inst.linkClk), .lineLaunchPulse(launch), .sampleStrobe(strobe),
        .videoPixel(lss_link_if_inst.videoPixel), .scanDoneFlag(done));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
        checkCount++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, input logic exp);
        checkVal({15'h0000, got}, {15'h0000, exp});
    endtask

    function automatic logic sigOf(input int sel);
        case (sel)
            0: sigOf = pixelStrobe;
            1: sigOf = launch;
            default: sigOf = busy;
        endcase
    endfunction

    // a run-out ends the run as a failure
    task automatic waitFor(input int sel, input logic lvl, input int limit, output int spent);
        spent = 0;
        while (sigOf(sel) !== lvl) begin
            @(negedge clk);
            spent++;
            if (spent > limit) begin
                checkBit(sigOf(sel), lvl);
                summarize();
            end
        end
    endtask

    task automatic checkIdle();
        checkVal({pixelNumber, pixelStrobe, lineDone, busy, integrating}, 16'h0000);
        checkVal({lss_link_if_inst.videoPixel, lss_link_if_inst.linkClk, launch, strobe, done},
            16'h0000);
        checkVal(integTime, 16'h0000);
    endtask

    task automatic readLine();
        int spent;
        for (int k = 0; k < PIX; k++) begin
            waitFor(0, 1'b1, 4000, spent);
            checkVal(16'(pixelNumber), 16'(rows[k].num));
            checkVal(16'(pixelValue), 16'(rows[k].num));
            checkBit(lineDone, rows[k].done);
            @(negedge clk);
        end
        checkVal(integTime, 16'(HIGH_EFF + 48));
        // run still high, so the launch side is never idle here
        checkBit(busy, 1'b1);
    endtask

    // one whole scan cycle measured on the wire itself
    task automatic measureWire();
        int spent;
        int strobes;
        int doneLen;
        int linkHigh;
        logic prev;
        waitFor(1, 1'b1, 3000, spent);
        waitFor(1, 1'b0, 3000, spent);
        checkVal(16'(spent), 16'(HIGH_EFF * LINK));
        // integration runs on past the launch fall for the tail
        checkBit(integrating, 1'b1);
        strobes = 0;
        doneLen = 0;
        linkHigh = 0;
        spent = 0;
        while (launch === 1'b0 && spent < 3000) begin
            prev = strobe;
            @(negedge clk);
            spent++;
            strobes += int'(strobe === 1'b1 && prev === 1'b0);
            doneLen += int'(done === 1'b1);
            linkHigh += int'(lss_link_if_inst.linkClk === 1'b1);
        end
        checkVal(16'(spent), 16'(LOW_SET * LINK));
        checkVal(16'(linkHigh), 16'(LOW_SET * LINK / 2));
        checkVal(16'(strobes), 16'(88 + PIX));
        checkVal(16'(doneLen), 16'(LINK));
        // the tail of 48 link periods ended well inside the low phase
        checkBit(integrating, 1'b0);
    endtask

    initial begin
        int spent;
        rst_b = 1'b0;
        run = 1'b0;
        fails = 0;
        checkCount = 0;
        for (int k = 0; k < PIX; k++) begin
            rows[k] = '{num: 12'(k), done: (k == PIX - 1)};
        end
        repeat (10) @(negedge clk);
        checkIdle();
        rst_b = 1'b1;
        run = 1'b1;
        readLine();
        measureWire();
        // reset lands in mid-readout, then a clean line must follow
        repeat (300) @(negedge clk);
        rst_b = 1'b0;
        @(negedge clk);
        checkIdle();
        repeat (9) @(negedge clk);
        rst_b = 1'b1;
        readLine();
        run = 1'b0;
        waitFor(2, 1'b0, 6000, spent);
        repeat (3000) @(negedge clk);
        checkBit(busy, 1'b0);
        checkBit(launch, 1'b0);
        summarize();
    end
endmodule
